// [inc/est_params.svh]
/*
  Offsets, field positions, reset values and counts for the event timer.
  Assumes a 12-bit APB byte address and 32-bit data, with each register
  taking one aligned word and its 8 bits in the low lane.
*/
`ifndef EST_PARAMS_SVH
`define EST_PARAMS_SVH

// register byte offsets
`define EST_OFF_CTRL      12'h000
`define EST_OFF_LOW       12'h004
`define EST_OFF_HBUF      12'h008
`define EST_OFF_INTC      12'h00c

// control field positions
`define EST_BIT_RUN       7
`define EST_BIT_NARROW    6
`define EST_BIT_SRC       5
`define EST_BIT_EDGE      4
`define EST_BIT_BYPASS    3
`define EST_PS_HI         2
`define EST_PS_LO         0

// interrupt control field positions
`define EST_BIT_IRQ_EN    5
`define EST_BIT_OVF_FLAG  2

// reset values
`define EST_RST_CTRL      8'hff
`define EST_RST_LOW       8'h00
`define EST_RST_HBUF      8'h00

// instruction cycles of increment suppression after a low byte write
`define EST_INHIBIT_CYC   2'h2
// sys_clk cycles per instruction cycle
`define EST_INSTR_DIV     4

`endif

// [inc/est_pkg.sv]
/*
  Types of the event timer: APB request and answer carriers and the
  whole state record of the timer.
  Assumes nothing beyond the parameter header.
*/
package est_pkg;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } est_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } est_apb_rsp_t;

  // every flip-flop of the timer
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  low;
    logic [7:0]  high;
    logic [7:0]  hbuf;
    logic [7:0]  presc;
    logic [1:0]  inhibit;
    logic        flag;
    logic        irq_en;
    logic [7:0]  div;
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic [31:0] prdata;
  } est_state_t;

endpackage

// [rtl/est_timer.sv]
/*
  Eight/sixteen bit event timer with prescaler, overflow flag and
  buffered high byte, reached over APB.
  Assumes sys_clk at 100 MHz, synchronous active-low nrst, sleep_req
  from logic on sys_clk, and an asynchronous external count pin.
*/
// What this block does
// R01 - run bit 7 set lets counter advance; cleared holds it stopped
// R02 - width bit 6 set gives eight-bit counter, cleared sixteen-bit
// R03 - source bit 5 cleared counts instruction cycles, set counts pin edges
// R04 - edge bit 4 set counts falling pin edges, cleared rising edges
// R05 - bypass bit 3 set skips prescaler; cleared counts prescaler output
// R06 - prescale field code n divides by two to the power n plus one
// R07 - timer mode without prescaler increments every instruction cycle
// R08 - low byte write suppresses increments for two instruction cycles
// R09 - low byte write clears prescaler count while prescaler assigned
// R10 - low byte write leaves the bypass setting unchanged
// R11 - prescaler assignment may change at any time while running
// R12 - overflow flag sets on rollover FFh or FFFFh to zero
// R13 - interrupt request masked when enable cleared; flag still sets
// R14 - software clears the flag before re-enabling; flag stays until cleared
// R15 - no counting during sleep, so overflow never wakes from sleep
// R16 - sixteen-bit low byte read copies high byte into buffer
// R17 - sixteen-bit low byte write loads high byte from buffer
// R18 - true high byte reachable only through the buffer register
// R19 - prescaler is eight-bit and neither readable nor writable
// R20 - external pin synchronised before counting, with some delay
// R21 - eight-bit mode counts low byte only; buffer unaffected by counting
`include "est_params.svh"

module est_timer #(
  parameter int INSTR_DIV = `EST_INSTR_DIV
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  // register bus
  input  wire est_pkg::est_apb_req_t apb_req,
  output      est_pkg::est_apb_rsp_t apb_rsp,
  // pins and chip state
  input  wire logic          external_count_pin,
  input  wire logic          sleep_req,
  output      logic          overflow_irq
);
  import est_pkg::*;

  localparam est_state_t RST_STATE = '{
    ctrl:    `EST_RST_CTRL,
    low:     `EST_RST_LOW,
    high:    8'h00,
    hbuf:    `EST_RST_HBUF,
    presc:   8'h00,
    inhibit: 2'h0,
    flag:    1'b0,
    irq_en:  1'b0,
    div:     8'h00,
    sync1:   1'b0,
    sync2:   1'b0,
    sync3:   1'b0,
    prdata:  32'h0000_0000
  };

  est_state_t st_r;
  est_state_t st_nxt;

  logic       instr_en;
  logic       narrow;
  logic       bypass;
  logic [2:0] ps_code;
  logic [7:0] ps_mask;
  logic       pin_edge;
  logic       src_tick;
  logic       cnt_tick;
  logic       cnt_inc;
  logic       full;
  logic       setup;
  logic       acc;
  logic       mapped;
  logic       sel_ctrl;
  logic       sel_low;
  logic       sel_hbuf;
  logic       sel_intc;
  logic       wr_low;
  logic       rd_low;
  logic [7:0] intc_view;
  logic [7:0] rd_mux;

  // instruction cycle enable from the sys_clk divider; the divider runs
  // free from reset and is never restarted, so the phase of the enable
  // against a register write is not fixed and tests must allow for it
  assign instr_en = (st_r.div == 8'(INSTR_DIV - 1));

  // control fields, read live every cycle: a control write takes hold
  // at the very next tick, with no staging register in between
  assign narrow  = st_r.ctrl[`EST_BIT_NARROW];
  assign bypass  = st_r.ctrl[`EST_BIT_BYPASS];
  assign ps_code = st_r.ctrl[`EST_PS_HI:`EST_PS_LO];

  // edge pick on the synchronised pin; sync1 feeds only sync2
  // sync3 is a plain delay of sync2, so a level that changes just before
  // a clock edge is counted one cycle late rather than twice
  assign pin_edge = st_r.ctrl[`EST_BIT_EDGE] ?
                    (st_r.sync3 & ~st_r.sync2) :   // [R04] [R20]
                    (st_r.sync2 & ~st_r.sync3);

  // count source, stopped by the run bit and by sleep
  // sleep gates the source itself, so the prescaler also stands still
  assign src_tick = st_r.ctrl[`EST_BIT_RUN] & ~sleep_req &  // [R01] [R15]
                    (st_r.ctrl[`EST_BIT_SRC] ? pin_edge : instr_en); // [R03]

  // prescaler fires when its low n+1 bits are all ones; bypass read live
  // each cycle so the assignment can change while running
  // the mask sum is taken at 16 bits because code 7 needs a ninth bit
  assign ps_mask  = 8'((16'h0002 << ps_code) - 16'h0001);   // [R06]
  assign cnt_tick = bypass ? src_tick :                     // [R05] [R11]
                    (src_tick & ((st_r.presc & ps_mask) == ps_mask));

  // bus decode; zero wait states, unmapped words answer with an error
  // only exact word addresses map; byte lanes other than the low one are
  // ignored on write and read back as zero
  assign setup    = apb_req.psel & ~apb_req.penable;
  assign acc      = apb_req.psel & apb_req.penable;
  assign sel_ctrl = (apb_req.paddr == `EST_OFF_CTRL);
  assign sel_low  = (apb_req.paddr == `EST_OFF_LOW);
  assign sel_hbuf = (apb_req.paddr == `EST_OFF_HBUF);
  assign sel_intc = (apb_req.paddr == `EST_OFF_INTC);
  assign mapped   = sel_ctrl | sel_low | sel_hbuf | sel_intc;
  assign wr_low   = acc & apb_req.pwrite & sel_low;
  assign rd_low   = setup & ~apb_req.pwrite & sel_low;

  // a low byte write owns the counter in its cycle
  // a tick that lands on the write is lost: the user is expected to write
  // an adjusted value, the same as during the two inhibit cycles
  assign cnt_inc = cnt_tick & (st_r.inhibit == 2'h0) & ~wr_low; // [R08]
  assign full    = (st_r.low == 8'hff) &
                   (narrow | (st_r.high == 8'hff));    // [R12] [R21]

  // interrupt control image, unused bits read as zero
  // the enable and flag are the only bits this block owns in that word
  always_comb
  begin
    intc_view = 8'h00;
    intc_view[`EST_BIT_IRQ_EN]   = st_r.irq_en;
    intc_view[`EST_BIT_OVF_FLAG] = st_r.flag;
  end

  // read data; the true high byte has no address of its own
  // later tests win, though only one select can be true at a time
  always_comb
  begin
    rd_mux = 8'h00;
    if (sel_ctrl)
      rd_mux = st_r.ctrl;
    if (sel_low)
      rd_mux = st_r.low;
    if (sel_hbuf)
      rd_mux = st_r.hbuf;                              // [R18]
    if (sel_intc)
      rd_mux = intc_view;
  end

  // next state; later assignments win, so writes beat counting and
  // a hardware overflow beats a software clear of the flag
  // the prescaler keeps counting through inhibit; only the counter's
  // own increment is held back
  always_comb
  begin
    st_nxt = st_r;
    // divider and synchroniser run in every state, even when stopped
    st_nxt.div   = instr_en ? 8'h00 : 8'(st_r.div + 8'h01);
    st_nxt.sync1 = external_count_pin;                 // [R20]
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    if (src_tick && !bypass)
      st_nxt.presc = 8'(st_r.presc + 8'h01);           // [R19]
    if (st_r.inhibit != 2'h0 && instr_en)
      st_nxt.inhibit = 2'(st_r.inhibit - 2'h1);
    if (cnt_inc)
    begin
      st_nxt.low = 8'(st_r.low + 8'h01);               // [R07]
      if (!narrow && st_r.low == 8'hff)
        st_nxt.high = 8'(st_r.high + 8'h01);           // [R02] [R21]
    end
    // read data and buffer snapshot taken together at setup, so both
    // bytes come from the same count
    if (setup && !apb_req.pwrite)
      st_nxt.prdata = {24'h000000, rd_mux};
    if (rd_low && !narrow)
      st_nxt.hbuf = st_r.high;                         // [R16]
    // register writes; the high byte is only ever reached via the buffer
    if (acc && apb_req.pwrite)
    begin
      if (sel_ctrl)
        st_nxt.ctrl = apb_req.pwdata[7:0];
      if (sel_hbuf)
        st_nxt.hbuf = apb_req.pwdata[7:0];
      if (sel_intc)
      begin
        st_nxt.irq_en = apb_req.pwdata[`EST_BIT_IRQ_EN];
        st_nxt.flag   = apb_req.pwdata[`EST_BIT_OVF_FLAG]; // [R14]
      end
      if (sel_low)
      begin
        st_nxt.low     = apb_req.pwdata[7:0];
        st_nxt.inhibit = `EST_INHIBIT_CYC;             // [R08]
        if (!narrow)
          st_nxt.high = st_r.hbuf;                     // [R17]
        if (!bypass)
          st_nxt.presc = 8'h00;                        // [R09] [R10]
      end
    end
    if (cnt_inc && full)
      st_nxt.flag = 1'b1;                              // [R12]
  end

  // the only clocked process
  // synchronous reset, so nrst must stay low across at least one edge
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      st_r <= RST_STATE;
    else
      st_r <= st_nxt;
  end

  // outputs; pready is tied high, every transfer has zero wait states
  // the request is a plain and of two flops, so it cannot glitch
  assign apb_rsp.prdata  = st_r.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc & ~mapped;
  assign overflow_irq    = st_r.flag & st_r.irq_en;    // [R13]

  // checks; all run on sys_clk and sleep while nrst is low. antecedents
  // leave out the cycle of a low write, which legally overrides counting
  // and, in sixteen-bit mode, the high byte
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  stop_hold_a: assert property (                        // [R01]
    (!st_r.ctrl[`EST_BIT_RUN] && !wr_low) |=> $stable(st_r.low))
    else $error("counter moved while stopped");

  narrow_high_a: assert property (                      // [R21]
    (narrow && !wr_low) |=> $stable(st_r.high) && $stable(st_r.hbuf) ||
    $past(rd_low) || $past(acc && apb_req.pwrite && sel_hbuf))
    else $error("high byte changed in eight-bit mode");

  timer_step_a: assert property (                       // [R07]
    (st_r.ctrl[`EST_BIT_RUN] && !st_r.ctrl[`EST_BIT_SRC] && bypass &&
     !sleep_req && instr_en && st_r.inhibit == 2'h0 && !wr_low)
    |=> st_r.low == 8'($past(st_r.low) + 8'h01))
    else $error("timer missed an instruction cycle");

  inhibit_set_a: assert property (                      // [R08]
    wr_low |=> st_r.inhibit == 2'h2)
    else $error("inhibit count not loaded");

  inhibit_hold_a: assert property (                     // [R08]
    (st_r.inhibit != 2'h0 && !wr_low) |=> $stable(st_r.low))
    else $error("count advanced during inhibit");

  presc_clear_a: assert property (                      // [R09]
    (wr_low && !bypass) |=> st_r.presc == 8'h00 &&
    st_r.ctrl[`EST_BIT_BYPASS] == 1'b0)
    else $error("prescaler not cleared on low write");

  ovf_flag_a: assert property (                         // [R12]
    (cnt_inc && full) |=> st_r.flag && st_r.low == 8'h00)
    else $error("overflow did not set flag");

  irq_mask_a: assert property (                         // [R13]
    !st_r.irq_en |-> !overflow_irq)
    else $error("masked interrupt reached output");

  sleep_hold_a: assert property (                       // [R15]
    (sleep_req && !wr_low) |=> $stable(st_r.low) && $stable(st_r.high))
    else $error("timer counted during sleep");

  hbuf_snap_a: assert property (                        // [R16]
    (rd_low && !narrow) |=> st_r.hbuf == $past(st_r.high))
    else $error("high byte not captured on low read");

  hwrite_a: assert property (                           // [R17]
    (wr_low && !narrow) |=> st_r.high == $past(st_r.hbuf))
    else $error("high byte not loaded from buffer");

  // the prescaler stands still while bypassed
  presc_idle_a: assert property (                       // [R05]
    bypass |=> $stable(st_r.presc))
    else $error("prescaler moved while bypassed");

  // the prescaler advances once per source tick when assigned
  presc_step_a: assert property (                       // [R19]
    (src_tick && !bypass && !wr_low) |=>
    st_r.presc == 8'($past(st_r.presc) + 8'h01))
    else $error("prescaler missed a source tick");

  // no ratio lets the prescaler fire on an even count
  presc_even_a: assert property (                       // [R06]
    (src_tick && !bypass && !st_r.presc[0] && !wr_low) |=>
    $stable(st_r.low))
    else $error("prescaler fired on an even count");

  // a rising pin edge counts when rising edges are chosen
  pin_rise_a: assert property (                         // [R04]
    (st_r.ctrl[`EST_BIT_RUN] && st_r.ctrl[`EST_BIT_SRC] &&
     !st_r.ctrl[`EST_BIT_EDGE] && bypass && !sleep_req &&
     st_r.inhibit == 2'h0 && !wr_low && st_r.sync2 && !st_r.sync3)
    |=> st_r.low == 8'($past(st_r.low) + 8'h01))
    else $error("rising pin edge not counted");

  // in counter mode a quiet pin never moves the count
  pin_quiet_a: assert property (                        // [R03]
    (st_r.ctrl[`EST_BIT_SRC] && st_r.sync2 == st_r.sync3 && !wr_low)
    |=> $stable(st_r.low))
    else $error("count moved with a quiet pin");

  // in timer mode nothing counts between instruction cycles
  timer_gap_a: assert property (                        // [R07]
    (!st_r.ctrl[`EST_BIT_SRC] && !instr_en && !wr_low) |=>
    $stable(st_r.low))
    else $error("timer counted off the instruction cycle");

  // the pin passes both synchroniser stages in order
  sync_chain_a: assert property (                       // [R20]
    nrst |=> st_r.sync2 == $past(st_r.sync1) &&
    st_r.sync3 == $past(st_r.sync2))
    else $error("synchroniser stage skipped");

  // the flag stays set until software writes the word
  flag_keep_a: assert property (                        // [R12]
    (st_r.flag && !(acc && apb_req.pwrite && sel_intc)) |=> st_r.flag)
    else $error("overflow flag dropped by itself");

  // a buffer write never reaches the true high byte
  high_hidden_a: assert property (                      // [R18]
    (acc && apb_req.pwrite && sel_hbuf && !cnt_inc) |=>
    $stable(st_r.high))
    else $error("buffer write reached the high byte");

  // a low write loads the written byte
  low_load_a: assert property (                         // [R08]
    wr_low |=> st_r.low == $past(apb_req.pwdata[7:0]))
    else $error("low byte write lost");

  // a low write leaves the control word alone
  assign_keep_a: assert property (                      // [R10]
    wr_low |=> st_r.ctrl == $past(st_r.ctrl))
    else $error("low write changed the control word");

  // the divider never passes its last phase
  div_range_a: assert property (                        // [R07]
    st_r.div < 8'(INSTR_DIV))
    else $error("divider out of range");

  // eight-bit wrap sets the flag from the low byte alone
  narrow_wrap_a: assert property (                      // [R21]
    (cnt_inc && narrow && st_r.low == 8'hff) |=>
    st_r.low == 8'h00 && st_r.flag)
    else $error("eight-bit wrap missed");

  // an enabled flag always reaches the request output
  irq_follow_a: assert property (                       // [R13]
    (st_r.flag && st_r.irq_en) |-> overflow_irq)
    else $error("enabled flag not requested");

  // in eight-bit mode a low read leaves the buffer alone
  snap_skip_a: assert property (                        // [R21]
    (rd_low && narrow) |=> $stable(st_r.hbuf))
    else $error("buffer snapped in eight-bit mode");

  // the prescaler also sleeps
  sleep_presc_a: assert property (                      // [R15]
    (sleep_req && !wr_low) |=> $stable(st_r.presc))
    else $error("prescaler counted during sleep");

  // scenarios the bench should reach: both rollovers, pin counting, the
  // slowest prescale ratio and a low write while the timer runs
  inhibit_c: cover property (wr_low && st_r.ctrl[`EST_BIT_RUN]);
  ovf16_c:   cover property (cnt_inc && full && !narrow);
  ovf8_c:    cover property (cnt_inc && full && narrow);
  pin_cnt_c: cover property (cnt_inc && st_r.ctrl[`EST_BIT_SRC]);
  presc_c:   cover property (cnt_inc && !bypass && ps_code == 3'h7);

endmodule

// [tb/est_pulse_src.sv]
/*
  Pulse source that stands on the external count pin.
  Assumes the bench pulses start for one clock with n_edges valid.
*/
module est_pulse_src (
  // clock
  input  wire logic       sys_clk,
  // command from the bench
  input  wire logic       start,
  input  wire logic [7:0] n_edges,
  // pin and status
  output logic            pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_r;
  logic [2:0] gap_r;
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
    left_r = 8'h00;
    gap_r = 3'h0;
  end
  // eight clocks per level so the synchroniser never misses one
  always @(posedge sys_clk)
  begin
    if (start && !busy)
    begin
      left_r <= n_edges;
      busy <= 1'b1;
      gap_r <= 3'h0;
    end
    else if (busy)
    begin
      gap_r <= gap_r + 3'h1;
      if (gap_r == 3'h7)
      begin
        if (left_r == 8'h00) busy <= 1'b0;
        else
        begin
          pin <= ~pin;
          left_r <= left_r - 8'h01;
        end
      end
    end
  end
endmodule

// [tb/est_timer_tb_top.sv]
/*
  Self-checking bench of the event timer: APB master, read monitor.
  Assumes zero-wait APB and the pulse source on the count pin.
*/
`include "est_params.svh"
module est_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import est_pkg::*;
  typedef struct packed {
    logic        err;
    logic [31:0] mask;
    logic [31:0] val;
  } est_note_t;
  logic          sys_clk, nrst, sleep_req, start, pin, busy, ovf_irq;
  logic [7:0]    n_edges, h, l;
  est_apb_req_t  req;
  est_apb_rsp_t  rsp;
  est_note_t     q[$];
  est_note_t     nt;
  int            err_count, checks, cyc;
  localparam logic [11:0] a_ctl = `EST_OFF_CTRL;
  localparam logic [11:0] a_low = `EST_OFF_LOW;
  localparam logic [11:0] a_hb = `EST_OFF_HBUF;
  localparam logic [11:0] a_ic = `EST_OFF_INTC;
  est_timer #(.INSTR_DIV(4)) est_timer_inst (.sys_clk(sys_clk),
    .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
    .external_count_pin(pin), .sleep_req(sleep_req),
    .overflow_irq(ovf_irq));
  est_pulse_src est_pulse_src_inst (.sys_clk(sys_clk), .start(start),
    .n_edges(n_edges), .pin(pin), .busy(busy));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
             pwdata: {24'h0, d}};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] m,
                    input logic [7:0] v, input logic e = 1'b0);
    q.push_back('{err: e, mask: {24'h0, m}, val: {24'h0, v}});
    xfer(1'b0, a, 8'h00);
  endtask
  task automatic edges(input logic [7:0] n);
    start <= 1'b1;
    n_edges <= n;
    @(posedge sys_clk);
    start <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 400 && busy; i++) @(posedge sys_clk);
    repeat (10) @(posedge sys_clk);
  endtask
  // read monitor: oldest note against the answer of the access edge
  always @(posedge sys_clk)
  begin
    if (req.psel && req.penable && rsp.pready && !req.pwrite)
    begin
      nt = q.pop_front();
      chk({nt.err, nt.val}, {rsp.pslverr, rsp.prdata & nt.mask});
    end
  end
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      complete_run();
    end
  end
  initial
  begin
    {nrst, sleep_req, start, n_edges, req} = '0;
    void'($urandom(59));
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(a_ctl, 8'hff, 8'hff);
    rd(a_low, 8'hff, 8'h00);
    rd(a_hb, 8'hff, 8'h00);
    rd(a_ic, 8'hff, 8'h00);
    rd(12'h010, 8'hff, 8'h00, 1'b1);
    // stopped sixteen-bit: buffered high byte both ways
    h = 8'($urandom);
    l = 8'($urandom);
    xfer(1'b1, a_ctl, 8'h08);
    xfer(1'b1, a_hb, h);
    xfer(1'b1, a_low, l);
    xfer(1'b1, a_hb, ~h);
    rd(a_low, 8'hff, l);
    rd(a_hb, 8'hff, h);
    // sixteen-bit rollover with the request enabled
    xfer(1'b1, a_hb, 8'hff);
    xfer(1'b1, a_low, 8'hfe);
    xfer(1'b1, a_ic, 8'h20);
    xfer(1'b1, a_ctl, 8'h88);
    repeat (40) @(posedge sys_clk);
    xfer(1'b1, a_ctl, 8'h08);
    chk({32'h0, 1'b1}, {32'h0, ovf_irq});
    rd(a_ic, 8'hff, 8'h24);
    rd(a_low, 8'h00, 8'h00);
    rd(a_hb, 8'hff, 8'h00);
    // eight-bit rollover, request masked, buffer untouched
    xfer(1'b1, a_ic, 8'h00);
    rd(a_ic, 8'hff, 8'h00);
    xfer(1'b1, a_ctl, 8'h48);
    xfer(1'b1, a_hb, 8'h77);
    xfer(1'b1, a_low, 8'hfd);
    xfer(1'b1, a_ctl, 8'hc8);
    repeat (40) @(posedge sys_clk);
    xfer(1'b1, a_ctl, 8'h48);
    chk({32'h0, 1'b0}, {32'h0, ovf_irq});
    rd(a_ic, 8'hff, 8'h04);
    rd(a_hb, 8'hff, 8'h77);
    // prescaler 1:256 then 1:2
    xfer(1'b1, a_ic, 8'h00);
    xfer(1'b1, a_ctl, 8'h07);
    xfer(1'b1, a_hb, 8'h00);
    xfer(1'b1, a_low, 8'h00);
    rd(a_ctl, 8'hff, 8'h07);
    xfer(1'b1, a_ctl, 8'h87);
    repeat (200) @(posedge sys_clk);
    xfer(1'b1, a_ctl, 8'h07);
    rd(a_low, 8'hff, 8'h00);
    xfer(1'b1, a_ctl, 8'h00);
    xfer(1'b1, a_low, 8'h00);
    xfer(1'b1, a_ctl, 8'h80);
    repeat (40) @(posedge sys_clk);
    xfer(1'b1, a_ctl, 8'h00);
    rd(a_low, 8'hf8, 8'h00);
    // pin counting: rising, falling, then asleep
    xfer(1'b1, a_ctl, 8'h08);
    xfer(1'b1, a_low, 8'h00);
    xfer(1'b1, a_ctl, 8'ha8);
    edges(8'd5);
    rd(a_low, 8'hff, 8'h03);
    xfer(1'b1, a_ctl, 8'hb8);
    xfer(1'b1, a_low, 8'h00);
    edges(8'd5);
    rd(a_low, 8'hff, 8'h03);
    xfer(1'b1, a_low, 8'h00);
    sleep_req <= 1'b1;
    edges(8'd4);
    rd(a_low, 8'hff, 8'h00);
    sleep_req <= 1'b0;
    repeat (4) @(posedge sys_clk);
    complete_run();
  end
endmodule
